// file: rtl/led_key_scanner.sv
// Purpose: six-digit multiplexed led driver with 8x6 key matrix scanner
// Assumes: two-wire host link on scl/sda pins, one 10 MHz clock
// Notes:   index 0 of the digit bus is digit line 2, index 5 is line 7

`timescale 1ns/1ps
`default_nettype none

module led_key_scanner #(
    parameter int DWELL_CYCLES = led_key_pkg::DWELL_CYCLES,
    parameter int BLANK_CYCLES = led_key_pkg::BLANK_CYCLES,
    parameter int KEY_RATIO    = led_key_pkg::KEY_RATIO,
    parameter int POR_CYCLES   = led_key_pkg::POR_CYCLES
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // two-wire host link
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // led / key matrix
    output logic [5:0]      digit_drive_lines,
    output logic [7:0]      segment_lines_out,
    output logic [7:0]      segment_lines_oe,
    input  wire logic [7:0] segment_lines_in,
    // host side signals
    output logic            key_int_out,
    output logic            key_int_oe,
    output logic            power_on_reset_out
);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic       scl_meta;
    logic       scl_sync;
    logic       scl_prev;
    logic       sda_meta;
    logic       sda_sync;
    logic       sda_prev;
    logic [7:0] seg_meta;
    logic [7:0] seg_sync;

    always_ff @(posedge clock) begin
        scl_meta <= scl_in;
        scl_sync <= scl_meta;
        scl_prev <= scl_sync;
        sda_meta <= sda_in;
        sda_sync <= sda_meta;
        sda_prev <= sda_sync;
        seg_meta <= segment_lines_in;
        seg_sync <= seg_meta;
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-up reset pulse to the host

    logic [31:0] por_cnt;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            por_cnt            <= '0;
            power_on_reset_out <= 1'b1;
        end else if (por_cnt < 32'(POR_CYCLES)) begin
            por_cnt            <= por_cnt + 32'h1;
            power_on_reset_out <= 1'b1;
        end else begin
            power_on_reset_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // two-wire slave: framing, command byte, data byte

    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;
    logic       frame_active;
    logic [4:0] edge_cnt;
    logic [7:0] shift_in;
    logic [7:0] cmd_byte;
    logic [7:0] read_byte;
    logic       reading;
    logic       read_take;
    logic       write_done;
    logic [7:0] write_byte;
    logic       display_enable_bit;
    logic       keyscan_enable_bit;
    logic [6:0] key_code;

    assign scl_rise   = scl_sync && !scl_prev;
    assign scl_fall   = !scl_sync && scl_prev;
    assign start_seen = scl_sync && scl_prev && sda_prev && !sda_sync;
    assign stop_seen  = scl_sync && scl_prev && !sda_prev && sda_sync;
    assign write_byte = {shift_in[6:0], sda_sync};
    assign read_take  = frame_active && scl_rise && edge_cnt == led_key_pkg::EDGE_BYTE1_LAST
                        && write_byte == led_key_pkg::CMD_READ_KEY;
    assign write_done = frame_active && scl_rise && edge_cnt == led_key_pkg::EDGE_BYTE2_LAST
                        && !reading;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            frame_active <= 1'b0;
            edge_cnt     <= '0;
            shift_in     <= '0;
            cmd_byte     <= '0;
            reading      <= 1'b0;
            read_byte    <= '0;
        end else if (start_seen) begin
            frame_active <= 1'b1;
            edge_cnt     <= '0;
            reading      <= 1'b0;
        end else if (stop_seen) begin
            frame_active <= 1'b0;
            reading      <= 1'b0;
        end else if (frame_active && scl_rise) begin
            shift_in <= write_byte;
            if (edge_cnt < led_key_pkg::EDGE_LIMIT) begin
                edge_cnt <= edge_cnt + 5'h1;
            end
            if (edge_cnt == led_key_pkg::EDGE_BYTE1_LAST) begin
                cmd_byte <= write_byte;
            end
            if (read_take) begin
                reading   <= 1'b1;
                read_byte <= {1'b0, key_code};
            end
        end
    end

    // read data changes on scl falling edges, msb first
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sda_out <= 1'b1;
            sda_oe  <= 1'b0;
        end else if (start_seen || stop_seen) begin
            sda_out <= 1'b1;
            sda_oe  <= 1'b0;
        end else if (scl_fall) begin
            if (reading && edge_cnt >= led_key_pkg::EDGE_ACK1
                && edge_cnt <= led_key_pkg::EDGE_BYTE2_LAST) begin
                sda_out <= read_byte[3'(led_key_pkg::EDGE_BYTE2_LAST - edge_cnt)];
                sda_oe  <= 1'b1;
            end else begin
                sda_out <= 1'b1;
                sda_oe  <= 1'b0;
            end
        end
    end

    // system parameter command
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            display_enable_bit <= 1'b0;
            keyscan_enable_bit <= 1'b0;
        end else if (write_done && cmd_byte == led_key_pkg::CMD_SET_SYSTEM) begin
            display_enable_bit <= write_byte[led_key_pkg::DISPLAY_EN_POS];
            keyscan_enable_bit <= write_byte[led_key_pkg::KEYSCAN_EN_POS];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pattern registers: deliberately without reset so a reset keeps the image

    logic [7:0] pattern [led_key_pkg::DIGIT_COUNT];
    logic [7:0] load_offset;
    logic       load_hit;

    assign load_offset = cmd_byte - led_key_pkg::CMD_LOAD_FIRST;
    assign load_hit    = cmd_byte >= led_key_pkg::CMD_LOAD_FIRST
                         && cmd_byte <= led_key_pkg::CMD_LOAD_LAST && !cmd_byte[0];

    always_ff @(posedge clock) begin
        if (write_done && load_hit) begin
            pattern[load_offset[3:1]] <= write_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // scan sequencer

    led_key_pkg::scan_phase_t phase;
    logic [31:0] dwell_cnt;
    logic [2:0]  slot;
    logic [7:0]  frame_cnt;
    logic        dwell_end;
    logic        blank;

    assign dwell_end = dwell_cnt == 32'(DWELL_CYCLES - 1);
    assign blank     = dwell_cnt < 32'(BLANK_CYCLES);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dwell_cnt <= '0;
            slot      <= '0;
            frame_cnt <= '0;
            phase     <= led_key_pkg::PH_DISPLAY;
        end else if (!dwell_end) begin
            dwell_cnt <= dwell_cnt + 32'h1;
        end else begin
            dwell_cnt <= '0;
            if (slot != 3'(led_key_pkg::DIGIT_COUNT - 1)) begin
                slot <= slot + 3'h1;
            end else begin
                slot <= '0;
                unique case (phase)
                    led_key_pkg::PH_DISPLAY: begin
                        if (frame_cnt >= 8'(KEY_RATIO - 1) && keyscan_enable_bit) begin
                            frame_cnt <= '0;
                            phase     <= led_key_pkg::PH_KEYS;
                        end else if (frame_cnt < 8'(KEY_RATIO - 1)) begin
                            frame_cnt <= frame_cnt + 8'h1;
                        end
                    end
                    led_key_pkg::PH_KEYS: begin
                        phase <= led_key_pkg::PH_DISPLAY;
                    end
                endcase
            end
        end
    end

    // pin drive; the blank gap at the start of every slot stops ghosting
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            digit_drive_lines <= '1;
            segment_lines_out <= '0;
            segment_lines_oe  <= '1;
        end else begin
            unique case (phase)
                led_key_pkg::PH_DISPLAY: begin
                    segment_lines_oe <= '1;
                    if (display_enable_bit && !blank) begin
                        digit_drive_lines <= ~(6'h01 << slot);
                        segment_lines_out <= pattern[slot];
                    end else begin
                        digit_drive_lines <= '1;
                        segment_lines_out <= '0;
                    end
                end
                led_key_pkg::PH_KEYS: begin
                    segment_lines_oe  <= '0;
                    segment_lines_out <= '0;
                    if (blank) begin
                        digit_drive_lines <= '0;
                    end else begin
                        digit_drive_lines <= 6'h01 << slot;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // key detection

    logic       best_valid;
    logic [5:0] best_code;
    logic       prev_valid;
    logic [5:0] prev_code;
    logic       low_found;
    logic [2:0] low_seg;
    logic [5:0] slot_code;
    logic       scan_valid;
    logic [5:0] scan_code;
    logic       key_sample;
    logic       scan_end;
    logic       press_event;

    // lowest closed segment gives the smallest code within one digit
    always_comb begin
        low_found = 1'b0;
        low_seg   = '0;
        for (int i = led_key_pkg::SEG_COUNT - 1; i >= 0; i--) begin
            if (seg_sync[i]) begin
                low_found = 1'b1;
                low_seg   = 3'(i);
            end
        end
    end

    assign slot_code  = {low_seg, slot + led_key_pkg::FIRST_DIGIT_LINE};
    assign key_sample = phase == led_key_pkg::PH_KEYS && dwell_end;
    assign scan_end   = key_sample && slot == 3'(led_key_pkg::DIGIT_COUNT - 1);

    always_comb begin
        scan_valid = best_valid;
        scan_code  = best_code;
        if (low_found && (!best_valid || slot_code < best_code)) begin
            scan_valid = 1'b1;
            scan_code  = slot_code;
        end
    end

    assign press_event = scan_end && scan_valid && prev_valid && scan_code == prev_code
                         && !(key_code[led_key_pkg::KEY_PRESSED_POS] && key_code[5:0] == scan_code);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            best_valid <= 1'b0;
            best_code  <= '0;
            prev_valid <= 1'b0;
            prev_code  <= '0;
        end else if (scan_end) begin
            best_valid <= 1'b0;
            best_code  <= '0;
            prev_valid <= scan_valid;
            prev_code  <= scan_code;
        end else if (key_sample) begin
            best_valid <= scan_valid;
            best_code  <= scan_code;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            key_code <= '0;
        end else if (press_event) begin
            key_code <= {1'b1, scan_code};
        end else if (scan_end && !scan_valid && !prev_valid) begin
            key_code[led_key_pkg::KEY_PRESSED_POS] <= 1'b0;
        end
    end

    // open-drain interrupt: enable low-drive only while pending, a new press beats a read
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            key_int_out <= 1'b0;
            key_int_oe  <= 1'b0;
        end else if (press_event) begin
            key_int_oe  <= 1'b1;
        end else if (read_take) begin
            key_int_oe  <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// file: shared/led_key_pkg.sv
// Purpose: constants shared by the led scan / key matrix scanner
// Assumes: 10 MHz core clock
// Notes:   times are kept in their own unit, cycle counts derive from them

`default_nettype none

package led_key_pkg;

    // core clock
    localparam int CLOCK_HZ = 10_000_000;

    // scan timing: per-digit dwell, blanking gap, display frames per key scan
    localparam int DWELL_US     = 500;
    localparam int DWELL_CYCLES = (DWELL_US * (CLOCK_HZ / 1_000_000));
    localparam int BLANK_NS     = 2000;
    localparam int BLANK_CYCLES = (BLANK_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
    localparam int KEY_RATIO    = 4;

    // power-on reset pulse width to the host
    localparam int POR_US     = 1000;
    localparam int POR_CYCLES = (POR_US * (CLOCK_HZ / 1_000_000));

    // matrix shape
    localparam int DIGIT_COUNT = 6;
    localparam int SEG_COUNT   = 8;
    localparam logic [2:0] FIRST_DIGIT_LINE = 3'h2;

    // serial commands (first byte)
    localparam logic [7:0] CMD_SET_SYSTEM = 8'h48;
    localparam logic [7:0] CMD_READ_KEY   = 8'h4f;
    localparam logic [7:0] CMD_LOAD_FIRST = 8'h64;
    localparam logic [7:0] CMD_LOAD_LAST  = 8'h6e;

    // system parameter byte fields
    localparam int DISPLAY_EN_POS = 0;
    localparam int KEYSCAN_EN_POS = 1;

    // key code fields
    localparam int KEY_PRESSED_POS = 6;
    localparam int KEY_SEG_LSB     = 3;
    localparam int KEY_DIG_LSB     = 0;

    // pattern bit for the decimal point; bits 6..0 are segments g..a
    localparam int PATTERN_DP_POS = 7;

    // serial rising-edge counts within a frame
    localparam logic [4:0] EDGE_BYTE1_LAST = 5'h07;
    localparam logic [4:0] EDGE_ACK1       = 5'h09;
    localparam logic [4:0] EDGE_BYTE2_LAST = 5'h10;
    localparam logic [4:0] EDGE_LIMIT      = 5'h12;

    // scan phases
    typedef enum logic {
        PH_DISPLAY,
        PH_KEYS
    } scan_phase_t;

endpackage

`default_nettype wire

// file: sim/led_key_scanner_properties.sv
// Purpose: port-level checks for the led scan / key scanner
// Assumes: one clock domain, synchronous active-low reset
// Notes:   the order check skips long dark gaps, such as a display re-enable
`timescale 1ns/1ps
`default_nettype none
module led_key_scanner_properties #(
    parameter int BLANK_CYCLES = 4,
    parameter int POR_CYCLES   = 10
) (
    // clock, reset and link
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    // matrix and host pins
    input wire logic [5:0] digit_drive_lines,
    input wire logic [7:0] segment_lines_out,
    input wire logic [7:0] segment_lines_oe,
    input wire logic [7:0] segment_lines_in,
    input wire logic       key_int_out,
    input wire logic       key_int_oe,
    input wire logic       power_on_reset_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    logic        display_enable_bit_one;
    logic        key_one;
    logic [5:0]  vis;
    logic [2:0]  cur_idx;
    logic [2:0]  last_idx;
    logic [7:0]  gap;
    logic [3:0]  since_key;
    logic [15:0] por_cnt;
    assign display_enable_bit_one = (segment_lines_oe == 8'hff) && $onehot(~digit_drive_lines);
    assign key_one  = (segment_lines_oe == 8'h00) && $onehot(digit_drive_lines);
    assign vis      = display_enable_bit_one ? ~digit_drive_lines : digit_drive_lines;
    always_comb begin
        cur_idx = 3'h0;
        for (int i = 0; i < 6; i++) begin
            if (vis[i]) begin
                cur_idx = 3'(i);
            end
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            last_idx  <= 3'h5;
            gap       <= 8'hff;
            since_key <= 4'hf;
            por_cnt   <= 16'h0;
        end else begin
            if (display_enable_bit_one || key_one) begin
                last_idx <= cur_idx;
                gap      <= 8'h00;
            end else if (gap != 8'hff) begin
                gap <= gap + 8'h01;
            end
            if (segment_lines_oe == 8'h00) begin
                since_key <= 4'h0;
            end else if (since_key != 4'hf) begin
                since_key <= since_key + 4'h1;
            end
            if (por_cnt != 16'hffff) begin
                por_cnt <= por_cnt + 16'h1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_one_lit;
        segment_lines_oe == 8'hff |-> $onehot0(~digit_drive_lines);
    endproperty
    a_one_lit: assert property (p_one_lit)
        else $error("more than one digit sinking");
    property p_key_drive;
        segment_lines_oe == 8'h00 |-> $onehot0(digit_drive_lines);
    endproperty
    a_key_drive: assert property (p_key_drive)
        else $error("more than one digit high in key phase");
    property p_scan_order;
        (display_enable_bit_one || key_one) && (cur_idx != last_idx) && (gap <= 8'(BLANK_CYCLES + 2))
            |-> cur_idx == ((last_idx == 3'h5) ? 3'h0 : last_idx + 3'h1);
    endproperty
    a_scan_order: assert property (p_scan_order)
        else $error("digit scan out of order");
    property p_blank_digit;
        $changed(digit_drive_lines) && segment_lines_oe == 8'hff
            |-> segment_lines_out == 8'h00 || $past(segment_lines_out) == 8'h00;
    endproperty
    a_blank_digit: assert property (p_blank_digit)
        else $error("segments lit across a digit change");
    property p_blank_phase;
        $changed(segment_lines_oe) |-> segment_lines_out == 8'h00;
    endproperty
    a_blank_phase: assert property (p_blank_phase)
        else $error("segments lit across a phase change");
    property p_dark;
        segment_lines_oe == 8'hff && digit_drive_lines == 6'h3f |-> segment_lines_out == 8'h00;
    endproperty
    a_dark: assert property (p_dark)
        else $error("segments lit with no digit active");
    property p_int_drive;
        key_int_out == 1'b0 ##1 key_int_out == 1'b0;
    endproperty
    a_int_drive: assert property (p_int_drive)
        else $error("interrupt pin data not low");
    property p_por;
        power_on_reset_out == (por_cnt <= 16'(POR_CYCLES));
    endproperty
    a_por: assert property (p_por)
        else $error("power-on reset pulse width wrong");
    property p_int_after_scan;
        $rose(key_int_oe) |-> since_key <= 4'h4;
    endproperty
    a_int_after_scan: assert property (p_int_after_scan)
        else $error("interrupt raised away from a key scan");
endmodule
`default_nettype wire

// file: sim/key_matrix_model.sv
// Purpose: key matrix with pulled-down segment returns
// Assumes: contact index is segment * 6 + digit
// Notes:   an undriven open segment reads 0 through its pull-down
`timescale 1ns/1ps
`default_nettype none
module key_matrix_model (
    // scanner pins
    input  wire logic [5:0]  digit_drive_lines,
    input  wire logic [7:0]  seg_out,
    input  wire logic [7:0]  seg_oe,
    output logic [7:0]       seg_in,
    // closed contacts
    input  wire logic [47:0] keys
);
    always_comb begin
        for (int s = 0; s < 8; s++) begin
            seg_in[s] = seg_oe[s] ? seg_out[s] : |(keys[s*6 +: 6] & digit_drive_lines);
        end
    end
endmodule
`default_nettype wire

// file: sim/led_key_scanner_tb.sv
// Purpose: self-checking bench for the led scan / key scanner
// Assumes: shortened scan counts, host link bit-banged at 10 clocks a bit
// Notes:   checks are queued by the driver and judged by a watcher process
`timescale 1ns/1ps
`default_nettype none
module led_key_scanner_tb;
    typedef struct {
        int         kind;
        logic [7:0] exp;
        logic [7:0] mask;
        string      name;
    } check_t;
    logic        clock    = 1'b0;
    logic        rst_n    = 1'b0;
    logic        scl_in   = 1'b1;
    logic        host_sda = 1'b1;
    logic [47:0] keys     = 48'h0;
    logic        sda_out, sda_oe, key_int_out, key_int_oe, power_on_reset_out;
    logic [5:0]  digit_drive_lines;
    logic [7:0]  seg_out, seg_oe, seg_in, rd_byte;
    logic [7:0]  pat [6];
    int          mismatches = 0;
    int          cmp_count  = 0;
    check_t      exp_q [$];
    event        probe_ev;
    // released sda reads 1, standing in for the pull-up
    wire logic   sda_wire = sda_oe ? sda_out : host_sda;
    initial forever #50 clock = ~clock;
    led_key_scanner #(.DWELL_CYCLES(40), .BLANK_CYCLES(4), .KEY_RATIO(1), .POR_CYCLES(10)) uut (
        .clock(clock), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .digit_drive_lines(digit_drive_lines),
        .segment_lines_out(seg_out), .segment_lines_oe(seg_oe), .segment_lines_in(seg_in),
        .key_int_out(key_int_out), .key_int_oe(key_int_oe),
        .power_on_reset_out(power_on_reset_out));
    key_matrix_model u_keys (.digit_drive_lines(digit_drive_lines), .seg_out(seg_out),
        .seg_oe(seg_oe), .seg_in(seg_in), .keys(keys));
    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic note(input int k, input logic [7:0] e, input logic [7:0] m, input string n);
        exp_q.push_back('{k, e, m, n});
        -> probe_ev;
        #1;
    endtask
    // mode 1 waits for a pending interrupt, mode 0 for a lit digit pattern
    task automatic wait_for(input int mode, input logic [5:0] v);
        int n;
        n = 0;
        while (mode ? key_int_oe !== 1'b1 : (digit_drive_lines !== v || seg_oe !== 8'hff)) begin
            tick(1);
            n++;
            if (n > 3000) begin
                mismatches++;
                wrap_up();
            end
        end
    endtask
    // a short pause after scl falls keeps sda edges clear of start/stop detection
    task automatic sbit(input logic b, output logic s);
        host_sda = b;
        tick(4);
        scl_in = 1'b1;
        tick(5);
        s = sda_wire;
        scl_in = 1'b0;
        tick(1);
    endtask
    task automatic xfer(input logic [7:0] b1, input logic [7:0] b2);
        logic s;
        host_sda = 1'b0;
        tick(5);
        scl_in = 1'b0;
        tick(1);
        for (int i = 7; i >= 0; i--) sbit(b1[i], s);
        sbit(1'b1, s);
        for (int i = 7; i >= 0; i--) begin
            sbit(b2[i], s);
            rd_byte[i] = s;
        end
        sbit(1'b1, s);
        host_sda = 1'b0;
        tick(4);
        scl_in = 1'b1;
        tick(5);
        host_sda = 1'b1;
        tick(5);
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(probe_ev) begin
        check_t     c;
        logic [7:0] got;
        c = exp_q.pop_front();
        case (c.kind)
            0: got = seg_out;
            1: got = rd_byte;
            2: got = {2'h0, digit_drive_lines};
            3: got = {6'h0, key_int_out, key_int_oe};
            default: got = {7'h0, power_on_reset_out};
        endcase
        cmp_count++;
        if ((got & c.mask) !== (c.exp & c.mask)) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", c.name, c.exp & c.mask, got & c.mask);
        end
    end
    initial begin
        int d;
        int g;
        void'($urandom(6107));
        tick(2);
        rst_n = 1'b1;
        tick(3);
        note(3, 8'h00, 8'h03, "int_idle");
        note(4, 8'h01, 8'h01, "por_high");
        for (int i = 0; i < 6; i++) begin
            pat[i] = 8'($urandom);
            xfer(8'h64 + 8'(2 * i), pat[i]);
        end
        xfer(8'h65, ~pat[0]);
        note(4, 8'h00, 8'h01, "por_low");
        xfer(8'h48, 8'h01);
        for (int i = 0; i < 6; i++) begin
            wait_for(0, ~(6'h01 << i));
            tick(7);
            note(0, pat[i], 8'hff, "segments");
        end
        xfer(8'h48, 8'h00);
        tick(700);
        note(2, 8'h3f, 8'hff, "dark_digits");
        note(0, 8'h00, 8'hff, "dark_segments");
        xfer(8'h48, 8'h03);
        wait_for(0, 6'h3b);
        tick(7);
        note(0, pat[2], 8'hff, "kept_pattern");
        keys[25] = 1'b1;
        tick(60);
        keys = 48'h0;
        tick(1200);
        note(3, 8'h00, 8'h03, "bounce_int");
        keys[25] = 1'b1;
        keys[36] = 1'b1;
        wait_for(1, 6'h00);
        xfer(8'h4f, 8'hff);
        note(1, 8'h63, 8'hff, "key_code");
        note(3, 8'h00, 8'h03, "int_released");
        tick(1200);
        note(3, 8'h00, 8'h03, "no_repeat");
        xfer(8'h4f, 8'hff);
        note(1, 8'h63, 8'hff, "reread");
        keys = 48'h0;
        tick(1200);
        xfer(8'h4f, 8'hff);
        note(1, 8'h00, 8'hc0, "released");
        repeat (3) begin
            d = $urandom_range(5);
            g = $urandom_range(7);
            keys[g * 6 + d] = 1'b1;
            wait_for(1, 6'h00);
            xfer(8'h4f, 8'hff);
            note(1, 8'(8'h42 + g * 8 + d), 8'hff, "random_key");
            keys = 48'h0;
            tick(1200);
        end
        // a mid-run reset must clear the enables but keep the pattern image
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(3);
        note(4, 8'h01, 8'h01, "por_again");
        note(2, 8'h3f, 8'hff, "reset_dark");
        xfer(8'h48, 8'h01);
        note(4, 8'h00, 8'h01, "por_done");
        wait_for(0, 6'h37);
        tick(7);
        note(0, pat[3], 8'hff, "reset_kept");
        wrap_up();
    end
endmodule
bind led_key_scanner led_key_scanner_properties #(
    .BLANK_CYCLES(BLANK_CYCLES), .POR_CYCLES(POR_CYCLES)
) u_props (
    .clock(clock), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .digit_drive_lines(digit_drive_lines),
    .segment_lines_out(segment_lines_out), .segment_lines_oe(segment_lines_oe),
    .segment_lines_in(segment_lines_in), .key_int_out(key_int_out),
    .key_int_oe(key_int_oe), .power_on_reset_out(power_on_reset_out));
`default_nettype wire
